// file: common/uams_pkg.sv
// constants for the address-match and selection block
// assumes one 25 MHz system clock samples every pin of the host bus
package uams_pkg;

  // data path widths
  localparam int WORD_W = 12;
  localparam int BYTE_W = 8;
  localparam int RAW_W  = 10;

  // fill comma, raw ten-bit forms for both disparities and the byte form
  localparam logic [9:0] COMMA_RD_NEG = 10'h0fa;
  localparam logic [9:0] COMMA_RD_POS = 10'h305;
  localparam logic [7:0] COMMA_BYTE   = 8'hbc;

  // reset values
  localparam logic FILL_RD_RESET = 1'b0;
  localparam logic FLAG_N_RESET  = 1'b1;

  // positions of pins in the synchroniser vector
  localparam int PIN_AM       = 0;
  localparam int PIN_TX_FLUSH = 1;
  localparam int PIN_RX_FLUSH = 2;
  localparam int PIN_TX_EN    = 3;
  localparam int PIN_RX_EN    = 4;
  localparam int PIN_TX_CLK   = 5;
  localparam int PIN_RX_CLK   = 6;
  localparam int PIN_REF_CLK  = 7;
  localparam int PIN_REC_CLK  = 8;
  localparam int PIN_BYPASS_N = 9;
  localparam int PIN_PACKED   = 10;
  localparam int PIN_ENC_BYP  = 11;
  localparam int PIN_CASCADE  = 12;
  localparam int PIN_W        = 13;

endpackage

// file: common/uams_track_if.sv
// match and selection signals of one direction
// assumes the main module drives samples and the tracker answers
`timescale 1ns/10ps
interface uams_track_if;
  logic sample;
  logic am_low;
  logic flush_req;
  logic enable_act;
  logic prior_only;
  logic match;
  logic flush_addressed;
  logic selected;
  logic am_seen;
  logic select_next;

  modport track (
    input  sample,
    input  am_low,
    input  flush_req,
    input  enable_act,
    input  prior_only,
    output match,
    output flush_addressed,
    output selected,
    output am_seen,
    output select_next
  );

  modport user (
    output sample,
    output am_low,
    output flush_req,
    output enable_act,
    output prior_only,
    input  match,
    input  flush_addressed,
    input  selected,
    input  am_seen,
    input  select_next
  );
endinterface

// file: core/uams_match_track.sv
// match, flush-match and selection state of one bus direction
// assumes sample is a one-cycle pulse on each rising edge of the bus clock
`timescale 1ns/10ps
module uams_match_track (
  // clock and reset
  input wire logic     clk,
  input wire logic     rst,
  // direction signals
  uams_track_if.track  trk
);

  logic am_low_reg;
  logic match_reg;
  logic flush_reg;
  logic selected_reg;
  logic enable_prev_reg;
  wire  match_now;
  wire  match_ok;
  wire  entry;
  wire  select_next;
  wire  flush_next;

  assign match_now   = trk.am_low && !trk.flush_req;
  assign match_ok    = match_reg || (match_now && !trk.prior_only);
  assign entry       = trk.enable_act && !enable_prev_reg && match_ok && !flush_reg;
  assign select_next = trk.enable_act && (selected_reg || entry);
  assign flush_next  = trk.am_low && trk.flush_req && !select_next;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      am_low_reg      <= 1'b0;
      match_reg       <= 1'b0;
      flush_reg       <= 1'b0;
      selected_reg    <= 1'b0;
      enable_prev_reg <= 1'b0;
    end else if (trk.sample) begin
      am_low_reg      <= trk.am_low;
      match_reg       <= match_now;
      flush_reg       <= flush_next;
      selected_reg    <= select_next;
      enable_prev_reg <= trk.enable_act;
    end
  end

  assign trk.match           = match_reg;
  assign trk.flush_addressed = flush_reg;
  assign trk.selected        = selected_reg;
  assign trk.am_seen         = am_low_reg;
  assign trk.select_next     = select_next;

  a_flush_select_excl: assert property (@(posedge clk) disable iff (rst)
    !(flush_reg && selected_reg)) else $error("selection and flush sequence together");

  a_match_follows_pins: assert property (@(posedge clk) disable iff (rst)
    trk.sample |=> match_reg == ($past(trk.am_low) && !$past(trk.flush_req)))
    else $error("match does not follow sampled pins");

  a_select_leaves_idle: assert property (@(posedge clk) disable iff (rst)
    trk.sample && !trk.enable_act |=> !selected_reg)
    else $error("selection kept after enable dropped");

  a_select_holds_on: assert property (@(posedge clk) disable iff (rst)
    selected_reg && trk.sample && trk.enable_act |=> selected_reg)
    else $error("selection lost while enable held");

endmodule

// file: core/uams_top.sv
// address-match, flag driver and data selection control of the host port
// assumes every pin and bus clock is asynchronous to clk and is slower than clk/4
//
`timescale 1ns/10ps
module uams_top #(
  parameter int WORD_W = uams_pkg::WORD_W
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // shared select pin
  input  wire logic              addr_match_n,
  // transmit pins
  input  wire logic              transmit_bus_clock,
  input  wire logic              reference_clock,
  input  wire logic              transmit_flush_req_n,
  input  wire logic              transmit_enable_n,
  input  wire logic [WORD_W-1:0] transmit_word_in,
  // transmit flags
  output      logic              transmit_queue_full_n,
  output      logic              transmit_queue_full_n_oe,
  output      logic              transmit_queue_empty_n,
  output      logic              transmit_queue_empty_n_oe,
  // receive pins
  input  wire logic              receive_bus_clock,
  output      logic              receive_bus_clock_out,
  output      logic              receive_bus_clock_oe,
  input  wire logic              receive_flush_req_n,
  input  wire logic              receive_enable_n,
  output      logic [WORD_W-1:0] receive_word_out,
  output      logic              receive_word_out_oe,
  // receive flags
  output      logic              receive_queue_full_n,
  output      logic              receive_queue_full_n_oe,
  output      logic              receive_queue_empty_n,
  output      logic              receive_queue_empty_n_oe,
  // mode straps
  input  wire logic              queue_bypass_n,
  input  wire logic              byte_packed_mode,
  input  wire logic              encoder_bypass,
  input  wire logic              cascade_timing_select,
  // recovered character clock
  input  wire logic              recovered_char_clock,
  // internal queue status
  input  wire logic              tx_queue_full,
  input  wire logic              tx_queue_empty,
  input  wire logic              rx_queue_full,
  input  wire logic              rx_queue_empty,
  // transmit queue write side
  output      logic              tx_queue_write,
  output      logic [WORD_W-1:0] tx_queue_word,
  // receive queue read side
  output      logic              rx_queue_read,
  input  wire logic [WORD_W-1:0] rx_queue_word,
  // bypass character stream
  output      logic              line_char_valid,
  output      logic [WORD_W-1:0] line_char,
  output      logic              line_char_is_fill,
  output      logic              line_char_is_raw
);

  if (WORD_W < uams_pkg::RAW_W) begin
    $error("WORD_W must hold a raw ten-bit character");
  end

  // pin synchronisers
  logic [uams_pkg::PIN_W-1:0] pin_s1_reg;
  logic [uams_pkg::PIN_W-1:0] pin_s2_reg;
  logic [uams_pkg::PIN_W-1:0] pin_s3_reg;
  logic [WORD_W-1:0]          word_s1_reg;
  logic [WORD_W-1:0]          word_s2_reg;
  wire  [uams_pkg::PIN_W-1:0] pin_raw;

  assign pin_raw = {cascade_timing_select, encoder_bypass, byte_packed_mode, queue_bypass_n,
                    recovered_char_clock, reference_clock, receive_bus_clock,
                    transmit_bus_clock, receive_enable_n, transmit_enable_n,
                    receive_flush_req_n, transmit_flush_req_n, addr_match_n};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_s1_reg  <= '0;
      pin_s2_reg  <= '0;
      pin_s3_reg  <= '0;
      word_s1_reg <= '0;
      word_s2_reg <= '0;
    end else begin
      pin_s1_reg  <= pin_raw;
      pin_s2_reg  <= pin_s1_reg;
      pin_s3_reg  <= pin_s2_reg;
      word_s1_reg <= transmit_word_in;
      word_s2_reg <= word_s1_reg;
    end
  end

  // decoded pins and modes
  wire cascade    = pin_s2_reg[uams_pkg::PIN_CASCADE];
  wire bypass     = !pin_s2_reg[uams_pkg::PIN_BYPASS_N];
  wire packed_on  = pin_s2_reg[uams_pkg::PIN_PACKED];
  wire enc_bypass = pin_s2_reg[uams_pkg::PIN_ENC_BYP];
  wire am_low     = !pin_s2_reg[uams_pkg::PIN_AM];
  wire tx_flush   = !pin_s2_reg[uams_pkg::PIN_TX_FLUSH];
  wire rx_flush   = !pin_s2_reg[uams_pkg::PIN_RX_FLUSH];
  wire tx_en_act  = pin_s2_reg[uams_pkg::PIN_TX_EN] ^ !cascade;
  wire rx_en_act  = pin_s2_reg[uams_pkg::PIN_RX_EN] ^ !cascade;

  // rising edges of the bus clocks
  wire [uams_pkg::PIN_W-1:0] pin_rise = pin_s2_reg & ~pin_s3_reg;
  wire tx_clk_rise  = pin_rise[uams_pkg::PIN_TX_CLK];
  wire ref_clk_rise = pin_rise[uams_pkg::PIN_REF_CLK];
  wire rx_clk_rise  = pin_rise[uams_pkg::PIN_RX_CLK];
  wire rec_clk_rise = pin_rise[uams_pkg::PIN_REC_CLK];
  wire tx_sync_mode = bypass && !packed_on;
  wire tx_sample    = tx_sync_mode ? ref_clk_rise : tx_clk_rise;
  wire rx_sample    = bypass ? rec_clk_rise : rx_clk_rise;

  // per-direction trackers
  uams_track_if tx_trk ();
  uams_track_if rx_trk ();

  assign tx_trk.sample     = tx_sample;
  assign tx_trk.am_low     = am_low;
  assign tx_trk.flush_req  = tx_flush;
  assign tx_trk.enable_act = tx_en_act;
  assign tx_trk.prior_only = 1'b0;
  assign rx_trk.sample     = rx_sample;
  assign rx_trk.am_low     = am_low;
  assign rx_trk.flush_req  = rx_flush;
  assign rx_trk.enable_act = rx_en_act;
  assign rx_trk.prior_only = bypass;

  uams_match_track u_tx_track (
    .clk (clk),
    .rst (rst),
    .trk (tx_trk)
  );

  uams_match_track u_rx_track (
    .clk (clk),
    .rst (rst),
    .trk (rx_trk)
  );

  // flag driver enables
  wire tx_flag_drive = tx_trk.match || tx_trk.flush_addressed;
  wire rx_flag_drive = bypass ? rx_trk.am_seen
                              : (rx_trk.match || rx_trk.flush_addressed);

  // flag pin levels by timing model
  wire tx_full_pin  = cascade ? tx_queue_full : !tx_queue_full;
  wire tx_empty_pin = cascade ? tx_queue_empty : !tx_queue_empty;
  wire rx_full_pin  = cascade ? rx_queue_full : !rx_queue_full;
  wire rx_empty_pin = cascade ? rx_queue_empty : !rx_queue_empty;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      transmit_queue_full_n  <= uams_pkg::FLAG_N_RESET;
      transmit_queue_empty_n <= uams_pkg::FLAG_N_RESET;
      receive_queue_full_n   <= uams_pkg::FLAG_N_RESET;
      receive_queue_empty_n  <= uams_pkg::FLAG_N_RESET;
    end else begin
      transmit_queue_full_n  <= tx_full_pin;
      transmit_queue_empty_n <= tx_empty_pin;
      receive_queue_full_n   <= rx_full_pin;
      receive_queue_empty_n  <= rx_empty_pin;
    end
  end

  assign transmit_queue_full_n_oe  = tx_flag_drive;
  assign transmit_queue_empty_n_oe = tx_flag_drive;
  assign receive_queue_full_n_oe   = rx_flag_drive;
  assign receive_queue_empty_n_oe  = rx_flag_drive;

  // transmit queue writes and bypass character stream
  logic              tx_write_reg;
  logic [WORD_W-1:0] tx_word_reg;
  logic              char_valid_reg;
  logic [WORD_W-1:0] char_reg;
  logic              char_fill_reg;
  logic              char_raw_reg;
  logic              fill_rd_reg;
  wire               tx_load   = tx_sample && tx_trk.select_next;
  wire               send_word = tx_load && tx_en_act;
  wire               fill_rd_next;
  wire [WORD_W-1:0]  fill_char;

  // raw fills alternate; with encoder the encoder keeps disparity
  assign fill_rd_next = !fill_rd_reg;
  assign fill_char    = enc_bypass ? WORD_W'(fill_rd_reg ? uams_pkg::COMMA_RD_POS
                                                         : uams_pkg::COMMA_RD_NEG)
                                   : WORD_W'(uams_pkg::COMMA_BYTE);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_write_reg <= 1'b0;
      tx_word_reg  <= '0;
    end else begin
      tx_write_reg <= tx_load && !tx_sync_mode;
      tx_word_reg  <= tx_load ? word_s2_reg : tx_word_reg;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      char_valid_reg <= 1'b0;
      char_reg       <= '0;
      char_fill_reg  <= 1'b0;
      char_raw_reg   <= 1'b0;
      fill_rd_reg    <= uams_pkg::FILL_RD_RESET;
    end else begin
      char_valid_reg <= tx_sample && tx_sync_mode;
      if (tx_sample && tx_sync_mode) begin
        char_reg      <= send_word ? word_s2_reg : fill_char;
        char_fill_reg <= !send_word;
        char_raw_reg  <= enc_bypass;
        fill_rd_reg   <= send_word ? fill_rd_reg : fill_rd_next;
      end
    end
  end

  assign tx_queue_write    = tx_write_reg;
  assign tx_queue_word     = tx_word_reg;
  assign line_char_valid   = char_valid_reg;
  assign line_char         = char_reg;
  assign line_char_is_fill = char_fill_reg;
  assign line_char_is_raw  = char_raw_reg;

  // receive reads, data bus and clock output
  logic              rx_read_reg;
  logic [WORD_W-1:0] rx_word_reg;
  logic              rx_clk_out_reg;
  wire               rx_take = rx_sample && rx_trk.select_next;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_read_reg    <= 1'b0;
      rx_word_reg    <= '0;
      rx_clk_out_reg <= 1'b0;
    end else begin
      rx_read_reg    <= rx_take && !bypass;
      rx_word_reg    <= rx_take ? rx_queue_word : rx_word_reg;
      rx_clk_out_reg <= pin_s2_reg[uams_pkg::PIN_REC_CLK];
    end
  end

  assign rx_queue_read         = rx_read_reg;
  assign receive_word_out      = rx_word_reg;
  assign receive_word_out_oe   = rx_trk.selected;
  assign receive_bus_clock_out = rx_clk_out_reg;
  assign receive_bus_clock_oe  = bypass;

  // history of the bypass character stream for the disparity check
  logic              chk_fill_raw_reg;
  logic [WORD_W-1:0] chk_char_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      chk_fill_raw_reg <= 1'b0;
      chk_char_reg     <= '0;
    end else if (line_char_valid) begin
      chk_fill_raw_reg <= line_char_is_fill && line_char_is_raw;
      chk_char_reg     <= line_char;
    end
  end

  // checks
  a_tx_flag_drive: assert property (@(posedge clk) disable iff (rst)
    tx_sample && !tx_flush |=> transmit_queue_full_n_oe == $past(am_low))
    else $error("transmit flag enable wrong");

  a_rx_flag_fifo: assert property (@(posedge clk) disable iff (rst)
    !bypass && rx_sample && !rx_flush |=> receive_queue_full_n_oe == $past(am_low))
    else $error("receive flag enable wrong");

  a_rx_flag_bypass: assert property (@(posedge clk) disable iff (rst)
    bypass && rx_sample |=> !$stable(bypass) || receive_queue_full_n_oe == $past(am_low))
    else $error("receive bypass flag enable not from match");

  a_rx_data_float: assert property (@(posedge clk) disable iff (rst)
    $rose(receive_word_out_oe) |-> $past(rx_sample) && $past(rx_en_act))
    else $error("receive bus driven without selection");

  a_rx_bypass_prior: assert property (@(posedge clk) disable iff (rst)
    bypass && rx_sample && !rx_trk.match && !rx_trk.selected |=> !receive_word_out_oe)
    else $error("receive bypass selected without prior match");

  a_rx_read_word: assert property (@(posedge clk) disable iff (rst)
    rx_take && !bypass |=> rx_queue_read && receive_word_out == $past(rx_queue_word))
    else $error("receive read word not presented");

  a_tx_refused: assert property (@(posedge clk) disable iff (rst)
    tx_sample && !am_low && !tx_trk.match && !tx_trk.selected |=> !tx_trk.selected)
    else $error("transmit selected without match");

  a_tx_write_word: assert property (@(posedge clk) disable iff (rst)
    tx_load && !tx_sync_mode |=> tx_queue_write && tx_queue_word == $past(word_s2_reg))
    else $error("selected transmit word not stored");

  a_no_write_bypass: assert property (@(posedge clk) disable iff (rst)
    tx_sync_mode ##1 tx_sync_mode |-> !tx_queue_write)
    else $error("queue written while bypassed");

  a_no_char_fifo: assert property (@(posedge clk) disable iff (rst)
    !tx_sync_mode ##1 !tx_sync_mode |-> !line_char_valid)
    else $error("bypass character sent with queue in use");

  a_word_sent_held: assert property (@(posedge clk) disable iff (rst)
    tx_sample && tx_sync_mode && tx_trk.selected && tx_en_act
    |=> line_char_valid && !line_char_is_fill && line_char == $past(word_s2_reg))
    else $error("held bypass word not sent");

  a_fill_when_idle: assert property (@(posedge clk) disable iff (rst)
    tx_sample && tx_sync_mode && !tx_en_act |=> line_char_valid && line_char_is_fill)
    else $error("idle bypass cycle sent no fill");

  a_fill_byte_form: assert property (@(posedge clk) disable iff (rst)
    line_char_valid && line_char_is_fill && !line_char_is_raw
    |-> line_char == WORD_W'(uams_pkg::COMMA_BYTE))
    else $error("encoded fill is not the comma byte");

  a_fill_alternates: assert property (@(posedge clk) disable iff (rst)
    line_char_valid && line_char_is_fill && line_char_is_raw && chk_fill_raw_reg
    |-> line_char != chk_char_reg)
    else $error("consecutive fills share disparity");

endmodule

// file: verif/uams_host_model.sv
// host-side bus master model: makes the bus clocks and drives the select pins
// assumes the bench orders match and enables itself and reads results at the ports
`timescale 1ns/10ps
module uams_host_model (
  // system clock
  input  wire logic        clk,
  // bus clocks
  output      logic        bus_clk,
  output      logic        rx_clk,
  // host pins
  output      logic        am_n,
  output      logic        tx_flush_n,
  output      logic        rx_flush_n,
  output      logic        tx_en,
  output      logic        rx_en,
  output      logic [11:0] word
);
  initial begin
    bus_clk    = 1'b0;
    rx_clk     = 1'b0;
    am_n       = 1'b1;
    tx_flush_n = 1'b1;
    rx_flush_n = 1'b1;
    tx_en      = 1'b1;
    rx_en      = 1'b1;
    word       = 12'h000;
  end

  // free running bus clocks, receive side lags by one system clock
  always #160 bus_clk = ~bus_clk;
  always @(bus_clk) rx_clk <= #40 bus_clk;

  // p is {match, tx flush, rx flush, tx enable, rx enable} as pin levels
  task automatic step(input logic [4:0] p, input logic [11:0] w);
    @(negedge bus_clk);
    @(posedge clk);
    am_n       <= p[4];
    tx_flush_n <= p[3];
    rx_flush_n <= p[2];
    tx_en      <= p[1];
    rx_en      <= p[0];
    word       <= w;
    @(posedge bus_clk);
    repeat (7) @(posedge clk);
    #1;
  endtask
endmodule

// file: verif/test_utopia_address_match_select.sv
// self-checking bench for the address-match and selection block
// assumes the host model makes the bus clocks and steps the select pins
`timescale 1ns/10ps
module test_utopia_address_match_select;
  localparam int W = uams_pkg::WORD_W;
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  logic         bypass_n = 1'b1;
  logic         cascade = 1'b0;
  logic         enc_byp = 1'b0;
  logic         txq_full = 1'b1;
  logic         txq_empty = 1'b0;
  logic         rxq_full = 1'b0;
  logic         rxq_empty = 1'b1;
  logic [W-1:0] rxq_word = 12'h0c7;
  logic         bus_clk, rx_clk, am_n, tx_flush_n, rx_flush_n, tx_en, rx_en;
  logic [11:0]  word;
  logic         tx_full_n, tx_full_oe, tx_empty_n, tx_empty_oe, rclk_out, rclk_oe;
  logic         rx_word_oe, rx_full_n, rx_full_oe, rx_empty_n, rx_empty_oe;
  logic         txq_wr, rxq_rd, lc_valid, lc_fill, lc_raw, lc_fill_q, lc_raw_q;
  logic [W-1:0] txq_word, rx_word, lc, wr_word, lc_last, lc_prev;
  int           num_errors = 0;
  int           checked = 0;
  int           wr_cnt = 0;
  int           rd_cnt = 0;
  int           rclk_rise = 0;
  wire logic    tx_clk = bus_clk & bypass_n;

  always #20 clk = ~clk;

  uams_host_model host (.clk(clk), .bus_clk(bus_clk), .rx_clk(rx_clk), .am_n(am_n),
    .tx_flush_n(tx_flush_n), .rx_flush_n(rx_flush_n), .tx_en(tx_en), .rx_en(rx_en),
    .word(word));

  uams_top dut (.clk(clk), .rst(rst), .addr_match_n(am_n), .transmit_bus_clock(tx_clk),
    .reference_clock(bus_clk), .transmit_flush_req_n(tx_flush_n),
    .transmit_enable_n(tx_en), .transmit_word_in(word),
    .transmit_queue_full_n(tx_full_n), .transmit_queue_full_n_oe(tx_full_oe),
    .transmit_queue_empty_n(tx_empty_n), .transmit_queue_empty_n_oe(tx_empty_oe),
    .receive_bus_clock(rx_clk), .receive_bus_clock_out(rclk_out),
    .receive_bus_clock_oe(rclk_oe), .receive_flush_req_n(rx_flush_n),
    .receive_enable_n(rx_en), .receive_word_out(rx_word), .receive_word_out_oe(rx_word_oe),
    .receive_queue_full_n(rx_full_n), .receive_queue_full_n_oe(rx_full_oe),
    .receive_queue_empty_n(rx_empty_n), .receive_queue_empty_n_oe(rx_empty_oe),
    .queue_bypass_n(bypass_n), .byte_packed_mode(1'b0), .encoder_bypass(enc_byp),
    .cascade_timing_select(cascade), .recovered_char_clock(rx_clk),
    .tx_queue_full(txq_full), .tx_queue_empty(txq_empty), .rx_queue_full(rxq_full),
    .rx_queue_empty(rxq_empty), .tx_queue_write(txq_wr), .tx_queue_word(txq_word),
    .rx_queue_read(rxq_rd), .rx_queue_word(rxq_word), .line_char_valid(lc_valid),
    .line_char(lc), .line_char_is_fill(lc_fill), .line_char_is_raw(lc_raw));

  // monitors of queue strobes and the bypass character stream
  always @(posedge clk) begin
    if (txq_wr === 1'b1) begin
      wr_cnt++;
      wr_word = txq_word;
    end
    if (rxq_rd === 1'b1) begin
      rd_cnt++;
    end
    if (lc_valid === 1'b1) begin
      lc_prev = lc_last;
      lc_last = lc;
      lc_fill_q = lc_fill;
      lc_raw_q = lc_raw;
    end
  end
  always @(posedge rclk_out) rclk_rise++;

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic stop_test;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic restart(input logic bn, input logic cs, input logic eb);
    @(posedge clk);
    rst <= 1'b1;
    bypass_n <= bn;
    cascade <= cs;
    enc_byp <= eb;
    repeat (5) @(posedge clk);
    #1;
    check("reset oe", {tx_full_oe, tx_empty_oe, rx_full_oe, rx_empty_oe, rx_word_oe}, 0);
    @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  // watchdog, about ten times the expected run
  initial begin
    #200000;
    num_errors++;
    stop_test();
  end

  initial begin
    restart(1'b1, 1'b0, 1'b0);
    host.step(5'h1f, 12'h000);
    check("tx flag oe idle", {tx_full_oe, tx_empty_oe}, 0);
    check("rx flag oe idle", {rx_full_oe, rx_empty_oe}, 0);
    host.step(5'h1d, 12'h111);
    host.step(5'h0d, 12'h222);
    check("refused write", wr_cnt, 0);
    check("tx flags", {tx_full_oe, tx_empty_oe, tx_full_n, tx_empty_n}, 4'hd);
    host.step(5'h0f, 12'h333);
    host.step(5'h0d, 12'h5a5);
    check("write word", wr_word, 12'h5a5);
    check("writes", wr_cnt, 1);
    host.step(5'h1d, 12'h3c3);
    check("held write", wr_word, 12'h3c3);
    check("tx oe off", tx_full_oe, 0);
    host.step(5'h1f, 12'h444);
    check("writes stop", wr_cnt, 4);
    host.step(5'h0f, 12'h000);
    host.step(5'h0e, 12'h000);
    check("rx data oe", rx_word_oe, 1);
    check("rx data", rx_word, 12'h0c7);
    check("rx reads", rd_cnt != 0, 1);
    check("rx flags", {rx_full_oe, rx_empty_oe, rx_full_n, rx_empty_n}, 4'he);
    host.step(5'h0f, 12'h000);
    check("rx data off", rx_word_oe, 0);
    host.step(5'h03, 12'h000);
    check("flush flags", {tx_full_oe, rx_full_oe}, 2'h3);
    host.step(5'h13, 12'h000);
    check("flush flags off", {tx_full_oe, rx_full_oe}, 2'h0);
    host.step(5'h0d, 12'h055);
    host.step(5'h05, 12'h0aa);
    check("select over flush", wr_word, 12'h0aa);
    host.step(5'h1c, 12'h000);
    restart(1'b1, 1'b1, 1'b0);
    host.step(5'h0c, 12'h000);
    check("cascade flags", {tx_full_n, tx_empty_n}, 2'h2);
    host.step(5'h0e, 12'h123);
    check("cascade write", wr_word, 12'h123);
    host.step(5'h1f, 12'h000);
    restart(1'b0, 1'b0, 1'b0);
    host.step(5'h1f, 12'h777);
    check("fill char", {lc_raw_q, lc_fill_q, lc_last}, {2'h1, 4'h0, uams_pkg::COMMA_BYTE});
    check("rx clk oe", rclk_oe, 1);
    host.step(5'h0e, 12'h000);
    check("rx same cycle", rx_word_oe, 0);
    check("tx flags ref clk", tx_full_oe, 1);
    check("rx flags bypass", rx_full_oe, 1);
    host.step(5'h0f, 12'h000);
    host.step(5'h04, 12'h2d2);
    check("bypass word", {lc_fill_q, lc_last}, {1'h0, 12'h2d2});
    check("rx select", rx_word_oe, 1);
    host.step(5'h14, 12'h1e1);
    check("held word", lc_last, 12'h1e1);
    check("held oe", {tx_full_oe, rx_full_oe, rx_word_oe}, 3'h1);
    host.step(5'h1f, 12'h1e1);
    check("fill again", lc_fill_q, 1);
    host.step(5'h1e, 12'h000);
    check("no fresh match", rx_word_oe, 0);
    check("rx clk out", rclk_rise != 0, 1);
    restart(1'b0, 1'b0, 1'b1);
    host.step(5'h1f, 12'h000);
    host.step(5'h1f, 12'h000);
    check("raw fill", {lc_raw_q, lc_fill_q}, 2'h3);
    check("fill disparity", lc_last ^ lc_prev, 12'h3ff);
    stop_test();
  end
endmodule
